// *** src/mmc_top.sv ***
// memory map controller: paging, debug overlay, arbitration, illegal reset
`timescale 1ns/1ps
`default_nettype none
`include "mmc_regs.svh"
module mmc_top #(
    parameter int RAM_SIZE   = 'h1800,  // ram_size_bytes
    parameter int FLASH_SIZE = 'h10000  // flash_size_bytes
) (
    input  wire logic                 ref_clk,          // system clock
    input  wire logic                 rst_b,            // async reset
    input  wire mmc_pkg::mmc_req_type cpu,              // processor request
    input  wire logic                 cpu_busy,         // mid operation
    input  wire logic                 cpu_fw_cmd,       // firmware command
    input  wire logic                 single_chip,      // single-chip mode
    input  wire mmc_pkg::mmc_req_type dbg,              // debug request
    input  wire logic                 dbg_active,       // active debug
    input  wire logic                 debug_read_cycle, // debug read cycle
    input  wire logic                 debug_write_cycle,// debug write cycle
    input  wire logic                 dbg_page_en,      // debug page enabled
    input  wire logic                 dbg_hw_cmd,       // debug hw command
    input  wire logic                 call_wr,          // far-call page load
    input  wire logic [3:0]           call_page,        // far-call page
    input  wire logic                 dbgpp_wr,         // debug page write
    input  wire logic [3:0]           dbgpp_wdata,      // debug page data
    input  wire logic [15:0]          tgt_rdata,        // target read data
    output var mmc_pkg::mmc_tgt_type  tgt_q,            // target bus
    output logic [15:0]               cpu_rdata_q,      // read data, odd byte reads swapped
    output logic [15:0]               dbg_rdata_q,      // debug read data
    output logic                      cpu_stall_q,      // processor stalled
    output logic                      dbg_stall_q,      // debug stalled
    output logic [3:0]                program_page_index_q, // page index
    output logic [3:0]                call_old_page_q,  // saved page
    output logic                      illegal_rst_q,    // illegal reset
    output logic                      irq_q             // always low
);
    ////////////////////////////////////////////////////////////////////
    logic [3:0]  debug_program_page_index_q;
    logic        grant_cpu;
    logic        grant_dbg;
    logic [17:0] cpu_glob;
    logic [17:0] dbg_glob;
    logic        cpu_dbg_hit;
    logic        dbg_dbg_hit;
    logic        cpu_impl;
    logic        dbg_impl;
    logic [3:0]  dbg_page;
    logic        cpu_page_acc;
    logic        dbg_page_acc;
    logic        last_cpu_q;
    logic        last_odd_q;
    logic        last_dbg_q;
    mmc_pkg::mmc_tgt_type tgt_d;

    function automatic logic [15:0] swap_bytes(input logic [15:0] d);
        swap_bytes = {d[7:0], d[15:8]};
    endfunction : swap_bytes

    // debug page index only when enabled and a command runs
    assign dbg_page = (dbg_page_en && (cpu_fw_cmd || dbg_hw_cmd)) ?
        debug_program_page_index_q : program_page_index_q;
    assign cpu_page_acc = cpu.req && cpu.addr == `MMC_PAGE_OFFSET;
    assign dbg_page_acc = dbg.req && dbg.addr == `MMC_PAGE_OFFSET;

    ////////////////////////////////////////////////////////////////////
    mmc_expand #(
        .RAM_SIZE   (RAM_SIZE),
        .FLASH_SIZE (FLASH_SIZE)
    ) u_cpu_exp (
        .local_addr  (cpu.addr),
        .page        (program_page_index_q),
        .dbg_active  (dbg_active),
        .glob_addr   (cpu_glob),
        .dbg_hit     (cpu_dbg_hit),
        .implemented (cpu_impl)
    );
    mmc_expand #(
        .RAM_SIZE   (RAM_SIZE),
        .FLASH_SIZE (FLASH_SIZE)
    ) u_dbg_exp (
        .local_addr  (dbg.addr),
        .page        (dbg_page),
        .dbg_active  (dbg_active),
        .glob_addr   (dbg_glob),
        .dbg_hit     (dbg_dbg_hit),
        .implemented (dbg_impl)
    );
    mmc_arbiter #(
        .STARVE (`MMC_STARVE_LIMIT)
    ) u_arb (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .cpu_req   (cpu.req && !cpu_page_acc),
        .dbg_req   (dbg.req && !dbg_page_acc),
        .cpu_busy  (cpu_busy),
        .grant_cpu (grant_cpu),
        .grant_dbg (grant_dbg)
    );

    ////////////////////////////////////////////////////////////////////
    // page index: far-call path wins over ordinary write
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            program_page_index_q <= `MMC_PAGE_RESET;
        else if (call_wr)
            program_page_index_q <= call_page;
        else if (cpu_page_acc && cpu.wr)
            program_page_index_q <= cpu.wdata[3:0];
        else if (dbg_page_acc && dbg.wr)
            program_page_index_q <= dbg.wdata[3:0];
    end

    // old page held for the far-call stacking step
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            call_old_page_q <= `MMC_PAGE_RESET;
        else if (call_wr)
            call_old_page_q <= program_page_index_q;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            debug_program_page_index_q <= 4'h0;
        else if (dbgpp_wr)
            debug_program_page_index_q <= dbgpp_wdata;
    end

    ////////////////////////////////////////////////////////////////////
    // target bus drive
    always_comb
    begin
        tgt_d = '0;
        if (grant_cpu)
        begin
            tgt_d.sel     = !cpu_dbg_hit;
            tgt_d.dbg_sel = cpu_dbg_hit &&
                (debug_read_cycle || debug_write_cycle);
            tgt_d.wr      = cpu.wr;
            tgt_d.word    = cpu.word;
            tgt_d.addr    = cpu_glob;
            tgt_d.wdata   = cpu.wdata;
        end
        else if (grant_dbg)
        begin
            tgt_d.sel     = !dbg_dbg_hit;
            tgt_d.dbg_sel = dbg_dbg_hit &&
                (debug_read_cycle || debug_write_cycle);
            tgt_d.wr      = dbg.wr;
            tgt_d.word    = dbg.word;
            tgt_d.addr    = dbg_glob;
            tgt_d.wdata   = dbg.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            tgt_q <= '0;
        else
            tgt_q <= tgt_d;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cpu_stall_q <= 1'b0;
            dbg_stall_q <= 1'b0;
            last_cpu_q  <= 1'b0;
            last_odd_q  <= 1'b0;
            last_dbg_q  <= 1'b0;
        end
        else
        begin
            cpu_stall_q <= cpu.req && !cpu_page_acc && !grant_cpu;
            dbg_stall_q <= dbg.req && !dbg_page_acc && !grant_dbg;
            last_cpu_q  <= grant_cpu && !cpu.wr;
            last_dbg_q  <= grant_dbg && !dbg.wr;
            last_odd_q  <= cpu.addr[0] && !cpu.word;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data return; processor odd byte reads swapped to low lane, debug reads unswapped
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cpu_rdata_q <= 16'h0000;
            dbg_rdata_q <= 16'h0000;
        end
        else
        begin
            if (cpu_page_acc && !cpu.wr)
                cpu_rdata_q <= {12'h000, program_page_index_q};
            else if (last_cpu_q)
                cpu_rdata_q <= last_odd_q ? swap_bytes(tgt_rdata) :
                    tgt_rdata;
            if (dbg_page_acc && !dbg.wr)
                dbg_rdata_q <= {12'h000, program_page_index_q};
            else if (last_dbg_q)
                dbg_rdata_q <= tgt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            illegal_rst_q <= 1'b0;
        else
            illegal_rst_q <= grant_cpu && single_chip && !cpu_fw_cmd &&
                !cpu_impl && !cpu_dbg_hit;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_q <= 1'b0;
        else
            irq_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // reset and far-call checks
    a_page_reset : assert property (
        @(posedge ref_clk)
        !rst_b ##1 rst_b |-> program_page_index_q == `MMC_PAGE_RESET)
        else $error("page index not reset value");

    sequence s_call_load;
        call_wr;
    endsequence : s_call_load

    sequence s_call_swap;
        program_page_index_q == $past(call_page) &&
            call_old_page_q == $past(program_page_index_q);
    endsequence : s_call_swap

    a_call_load : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        s_call_load |=> s_call_swap)
        else $error("far-call page swap wrong");

    a_call_hold : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !call_wr |=> $stable(call_old_page_q))
        else $error("saved page changed outside far call");

    // address mapping checks
    a_window_map : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        grant_cpu && cpu.addr[15:14] == 2'b10 |=>
        tgt_q.addr[17:14] == $past(program_page_index_q))
        else $error("window address wrong");

    a_unpaged_map : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        grant_cpu && cpu.addr[15:14] == 2'b11 |=>
        tgt_q.addr[17:14] == 4'hF)
        else $error("unpaged address paged");

    a_debug_hide : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        dbg_active && grant_cpu && cpu.addr >= `MMC_DBG_LOW |=> !tgt_q.sel)
        else $error("resource visible under debug");

    a_debug_only : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        tgt_q.dbg_sel |-> $past(debug_read_cycle || debug_write_cycle))
        else $error("debug resource outside debug cycle");

    a_dbg_page : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        grant_dbg && dbg.addr[15:14] == 2'b10 && dbg_page_en && dbg_hw_cmd
        |=> tgt_q.addr[17:14] == $past(debug_program_page_index_q))
        else $error("debug page index not applied");

    // access control and data return checks
    a_illegal_rst : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        illegal_rst_q |-> $past(single_chip && !cpu_fw_cmd && grant_cpu))
        else $error("illegal reset without cause");

    a_dbg_no_rst : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        grant_dbg |=> !illegal_rst_q)
        else $error("debug access raised reset");

    a_page_read : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        cpu_page_acc && !cpu.wr |=>
        cpu_rdata_q == {12'h000, $past(program_page_index_q)})
        else $error("page index read wrong");

    a_byte_swap : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        last_cpu_q && last_odd_q && !(cpu_page_acc && !cpu.wr) |=>
        cpu_rdata_q == swap_bytes($past(tgt_rdata)))
        else $error("odd byte read not swapped");

    a_dbg_rdata : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        last_dbg_q && !(dbg_page_acc && !dbg.wr) |=>
        dbg_rdata_q == $past(tgt_rdata))
        else $error("debug read data not returned");

    a_no_irq : assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !irq_q)
        else $error("interrupt raised");
endmodule : mmc_top
`default_nettype wire

// *** src/mmc_regs.svh ***
// constants of the memory map controller
// Contract
// - debug resources answer only in dedicated debug read and write cycles
// - in active debug, debug tables and registers map at local 0xFF00-0xFFFF
// - in active debug, other resources at those addresses are hidden
// - in active debug with page 0x0F, debug resources also at 0xBF00-0xBFFF
// - page index selects one of sixteen 16 kB blocks into 0x8000-0xBFFF
// - page index read and written by memory access and far-call path
// - local 0xC000-0xFFFF is unpaged, independent of page index
// - debug master expands addresses with its own debug page index
// - debug page index used only when enabled and a debug command runs
// - regs 0x0_0000-0x0_03FF, data flash 0x0_4400-0x0_53FF, RAM top 0x0_3FFF
// - program flash ends at 0x3_FFFF, starts at top minus flash size
// - processor access to unimplemented area in single-chip causes reset
// - debug access to unimplemented area allowed, data undefined
// - block drives target address and data, swaps processor read bytes
// - at most one master holds the target bus at a time
// - processor wins over debug master on contention
// - debug waiting over 128 cycles wins after processor's current access
// - block raises no interrupt request
// - far call saves page, loads new, pushes return address then old page
// - far-call sequence runs atomically, no interrupt intervenes
// - new page from immediate, or from memory for indexed-indirect form
// - page index resets to 0x0E
`ifndef MMC_REGS_SVH
`define MMC_REGS_SVH
`define MMC_PAGE_RESET      4'hE
`define MMC_PAGE_DEBUG_ALT  4'hF
`define MMC_PAGE_OFFSET     16'h0015
`define MMC_WIN_LOW         16'h8000
`define MMC_WIN_HIGH        16'hBFFF
`define MMC_UNPAGED_LOW     16'hC000
`define MMC_DBG_LOW         16'hFF00
`define MMC_DBG_ALT_LOW     16'hBF00
`define MMC_DBG_ALT_HIGH    16'hBFFF
`define MMC_REG_TOP         18'h003FF
`define MMC_RAM_TOP         18'h03FFF
`define MMC_RAM_END         18'h04000
`define MMC_DF_LOW          18'h04400
`define MMC_DF_TOP          18'h053FF
`define MMC_PF_END          19'h40000
`define MMC_STARVE_LIMIT    8'h80
`define MMC_FIXED_PAGE_LO   4'hC
`endif

// *** src/mmc_pkg.sv ***
// types shared by the memory map controller
package mmc_pkg;
    typedef struct packed {
        logic        req;
        logic        wr;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mmc_req_type;
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic        word;
        logic        dbg_sel;
        logic [17:0] addr;
        logic [15:0] wdata;
    } mmc_tgt_type;
    typedef enum logic [1:0] {
        MMC_OWN_NONE,
        MMC_OWN_CPU,
        MMC_OWN_DBG
    } mmc_owner_type;
endpackage : mmc_pkg

// *** src/mmc_expand.sv ***
// local to global address expansion and implemented area check
`timescale 1ns/1ps
`default_nettype none
`include "mmc_regs.svh"
module mmc_expand #(
    parameter int RAM_SIZE   = 'h1800, // ram_size_bytes
    parameter int FLASH_SIZE = 'h10000 // flash_size_bytes
) (
    input  wire logic [15:0] local_addr, // local address
    input  wire logic [3:0]  page,       // active page index
    input  wire logic        dbg_active, // active debug mode
    output logic      [17:0] glob_addr,  // global address
    output logic             dbg_hit,    // debug resource selected
    output logic             implemented // lands in implemented memory
);
    localparam logic [17:0] RAM_LOW =
        18'(`MMC_RAM_END - RAM_SIZE);
    localparam logic [17:0] PROGRAM_FLASH_BOTTOM_ADDRESS =
        18'(`MMC_PF_END - FLASH_SIZE);
    logic [3:0] blk;
    always_comb
    begin
        if (local_addr >= `MMC_UNPAGED_LOW)
            blk = `MMC_PAGE_DEBUG_ALT;
        else if (local_addr >= `MMC_WIN_LOW)
            blk = page;
        else
            blk = `MMC_FIXED_PAGE_LO + {3'h0, local_addr[14]};
        glob_addr = {blk, local_addr[13:0]};
        dbg_hit = dbg_active && ((local_addr >= `MMC_DBG_LOW) ||
            (page == `MMC_PAGE_DEBUG_ALT &&
             local_addr >= `MMC_DBG_ALT_LOW &&
             local_addr <= `MMC_DBG_ALT_HIGH));
        implemented = (glob_addr <= `MMC_REG_TOP) ||
            (glob_addr >= RAM_LOW && glob_addr <= `MMC_RAM_TOP) ||
            (glob_addr >= `MMC_DF_LOW && glob_addr <= `MMC_DF_TOP) ||
            (glob_addr >= PROGRAM_FLASH_BOTTOM_ADDRESS);
    end
endmodule : mmc_expand
`default_nettype wire

// *** src/mmc_arbiter.sv ***
// target bus arbiter with debug starvation escape
`timescale 1ns/1ps
`default_nettype none
`include "mmc_regs.svh"
module mmc_arbiter #(
    parameter int STARVE = `MMC_STARVE_LIMIT // debug wait limit
) (
    input  wire logic ref_clk,   // clock
    input  wire logic rst_b,     // async reset, active low
    input  wire logic cpu_req,   // processor wants bus
    input  wire logic dbg_req,   // debug master wants bus
    input  wire logic cpu_busy,  // processor mid operation
    output logic      grant_cpu, // processor owns bus
    output logic      grant_dbg  // debug owns bus
);
    logic [7:0] wait_q;
    logic       starved;
    assign starved = wait_q > 8'(STARVE);
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            wait_q <= 8'h00;
        else if (!dbg_req || grant_dbg)
            wait_q <= 8'h00;
        else if (!starved)
            wait_q <= wait_q + 8'h01;
    end
    always_comb
    begin
        grant_dbg = dbg_req && (!cpu_req ||
            (starved && !cpu_busy));
        grant_cpu = cpu_req && !grant_dbg;
    end
    a_one_owner : assert property (@(posedge ref_clk) disable iff (!rst_b)
        !(grant_cpu && grant_dbg))
        else $error("both masters granted");
    a_cpu_first : assert property (@(posedge ref_clk) disable iff (!rst_b)
        cpu_req && dbg_req && wait_q == 8'h00 |-> grant_cpu)
        else $error("processor not first");
    a_starve_win : assert property (@(posedge ref_clk) disable iff (!rst_b)
        dbg_req && !grant_dbg && !cpu_busy && wait_q == 8'(STARVE)
        |=> grant_dbg || !dbg_req || cpu_busy)
        else $error("starved debug not granted");
endmodule : mmc_arbiter
`default_nettype wire

// *** bench/mmc_tgt_model.sv ***
// target bus responder model for the memory map controller bench
`timescale 1ns/1ps
`default_nettype none
module mmc_tgt_model (
    input  wire logic                 ref_clk, // system clock
    input  wire logic                 rst_b,   // async reset, active low
    input  wire mmc_pkg::mmc_tgt_type tgt,     // target bus from block
    output logic [15:0]               rdata    // target read data
);
    logic [15:0] noise_q;

    ////////////////////////////////////////////////////////////////////////
    // unselected bus shows a changing pattern, never stale data
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            noise_q <= 16'h0000;
        else
            noise_q <= ~noise_q ^ 16'h1234;
    end

    // each address answers its own word while the access stands
    assign rdata = (tgt.sel || tgt.dbg_sel) ? (tgt.addr[15:0] ^ 16'h5A3C)
                                            : noise_q;
endmodule : mmc_tgt_model
`default_nettype wire

// *** bench/memory_map_controller_tb.sv ***
// self-checking bench of the memory map controller
`timescale 1ns/1ps
`default_nettype none
module memory_map_controller_tb;
    localparam int RAM_SZ = 'h1800;
    localparam int FL_SZ  = 'h10000;
    logic                 ref_clk, rst_b, cpu_busy, cpu_fw_cmd, single_chip;
    logic                 dbg_active, rd_cyc, wr_cyc, dbg_page_en;
    logic                 dbg_hw_cmd, call_wr, dbgpp_wr, ill, exp_b, hit;
    logic                 cpu_stall_q, dbg_stall_q, illegal_rst_q, irq_q;
    logic [3:0]           call_page, dbgpp_wdata, page_q, old_q, p;
    logic [15:0]          tgt_rdata, cpu_rdata_q, dbg_rdata_q, rd, a;
    logic [17:0]          g;
    logic [31:0]          rnd;
    mmc_pkg::mmc_req_type cpu_r, dbg_r;
    mmc_pkg::mmc_tgt_type tgt_q, t;
    int                   errors, compares, seed, n, i, k;
    logic [19:0] ill_tbl [8] = '{20'h08100, 20'h09000, 20'h0A800, 20'h18500,
                                 20'h19400, 20'hB8000, 20'hC8000, 20'h28000};
    logic [21:0] dbg_tbl [5] = '{22'h1EFF10, 22'h0EFF10, 22'h1FBF20,
                                 22'h1EBF20, 22'h2EFF40};

    mmc_top #(.RAM_SIZE(RAM_SZ), .FLASH_SIZE(FL_SZ)) DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .cpu(cpu_r), .cpu_busy(cpu_busy),
        .cpu_fw_cmd(cpu_fw_cmd), .single_chip(single_chip), .dbg(dbg_r),
        .dbg_active(dbg_active), .debug_read_cycle(rd_cyc),
        .debug_write_cycle(wr_cyc), .dbg_page_en(dbg_page_en),
        .dbg_hw_cmd(dbg_hw_cmd), .call_wr(call_wr), .call_page(call_page),
        .dbgpp_wr(dbgpp_wr), .dbgpp_wdata(dbgpp_wdata),
        .tgt_rdata(tgt_rdata), .tgt_q(tgt_q), .cpu_rdata_q(cpu_rdata_q),
        .dbg_rdata_q(dbg_rdata_q), .cpu_stall_q(cpu_stall_q),
        .dbg_stall_q(dbg_stall_q), .program_page_index_q(page_q),
        .call_old_page_q(old_q), .illegal_rst_q(illegal_rst_q),
        .irq_q(irq_q));
    mmc_tgt_model u_tgt (.ref_clk(ref_clk), .rst_b(rst_b), .tgt(tgt_q),
                         .rdata(tgt_rdata));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [17:0] glob(input logic [3:0] pg,
                                         input logic [15:0] ad);
        if (ad[15:14] == 2'b10)
            return {pg, ad[13:0]};
        return {2'b11, ad};
    endfunction : glob

    function automatic logic impl(input logic [17:0] ga);
        return ga <= 18'h003FF || ga >= 18'(32'h40000 - FL_SZ)
            || (ga >= 18'(32'h4000 - RAM_SZ) && ga <= 18'h03FFF)
            || (ga >= 18'h04400 && ga <= 18'h053FF);
    endfunction : impl

    task chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task chk_b(input string nm, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk_b

    task end_of_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task do_reset;
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
    endtask : do_reset

    // one uncontended access: request stands for exactly one grant edge
    task acc(input logic m, input logic [15:0] ad, input logic w,
             input logic wd, input logic [15:0] d);
        mmc_pkg::mmc_req_type r;
        r = '{1'b1, w, wd, ad, d};
        @(posedge ref_clk);
        if (m)
            dbg_r <= r;
        else
            cpu_r <= r;
        @(posedge ref_clk);
        cpu_r <= '0;
        dbg_r <= '0;
        #1;
        t = tgt_q;
        ill = illegal_rst_q;
        @(posedge ref_clk);
        #1;
        rd = m ? dbg_rdata_q : cpu_rdata_q;
        ill = ill | illegal_rst_q;
    endtask : acc

    task set_page(input logic [3:0] pg);
        @(posedge ref_clk);
        call_wr <= 1'b1;
        call_page <= pg;
        @(posedge ref_clk);
        call_wr <= 1'b0;
    endtask : set_page

    // both masters hold requests; returns cycle of the debug win
    task starve(input int busy_n, output int nn);
        @(posedge ref_clk);
        cpu_r <= '{1'b1, 1'b0, 1'b1, 16'hC100, 16'h0000};
        dbg_r <= '{1'b1, 1'b0, 1'b1, 16'h4010, 16'h0000};
        cpu_busy <= (busy_n > 0);
        nn = 999;
        for (k = 1; k < 300 && nn == 999; k++)
        begin
            @(posedge ref_clk);
            if (k == busy_n)
                cpu_busy <= 1'b0;
            #1;
            if (k == 1)
                chk("first owner", 18'h3C100, tgt_q.addr);
            if (k >= 2)
                chk_b("one owner", 1'b1, cpu_stall_q | dbg_stall_q);
            if (tgt_q.addr === 18'h34010)
                nn = k;
        end
        @(posedge ref_clk);
        cpu_r <= '0;
        dbg_r <= '0;
        cpu_busy <= 1'b0;
    endtask : starve

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial
    begin
        {rst_b, cpu_busy, cpu_fw_cmd, single_chip, dbg_active} = '0;
        {rd_cyc, wr_cyc, dbg_page_en, dbg_hw_cmd, call_wr, dbgpp_wr} = '0;
        {call_page, dbgpp_wdata, cpu_r, dbg_r} = '0;
        errors = 0;
        compares = 0;
        seed = 27;
        do_reset();
        @(posedge ref_clk);
        #1;
        chk("reset page", 18'h0000E, 18'(page_q));
        chk("reset saved", 18'h0000E, 18'(old_q));
        chk_b("irq", 1'b0, irq_q);
        set_page(4'h3);
        #1;
        chk("call page", 18'h00003, 18'(page_q));
        chk("call saved", 18'h0000E, 18'(old_q));
        acc(1'b0, 16'h0015, 1'b1, 1'b0, 16'h0005);
        chk("mem page wr", 18'h00005, 18'(page_q));
        acc(1'b0, 16'h0015, 1'b0, 1'b0, 16'h0000);
        chk("mem page rd", 18'h00005, 18'(rd[3:0]));
        // random paged and unpaged reads
        for (i = 0; i < 40; i++)
        begin
            rnd = $random(seed);
            p = rnd[19:16];
            a = {1'b1, rnd[14:0] & {14'h3FFF, ~rnd[20]}};
            set_page(p);
            acc(1'b0, a, 1'b0, rnd[20], 16'h0000);
            g = glob(p, a);
            chk("glob addr", g, t.addr);
            chk_b("sel", 1'b1, t.sel);
            if (rnd[20])
                chk("word data", 18'(g[15:0] ^ 16'h5A3C), 18'(rd));
            else if (a[0])
                chk("swap byte", 18'(g[15:8] ^ 8'h5A), 18'(rd[7:0]));
        end
        // vector fetch stays in unpaged space whatever the page
        acc(1'b0, 16'hFFFE, 1'b0, 1'b1, 16'h0000);
        chk("vector addr", 18'h3FFFE, t.addr);
        single_chip <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            set_page(ill_tbl[i][19:16]);
            acc(1'b0, ill_tbl[i][15:0], 1'b0, 1'b1, 16'h0000);
            exp_b = ~impl(glob(ill_tbl[i][19:16], ill_tbl[i][15:0]));
            chk_b("illegal", exp_b, ill);
        end
        cpu_fw_cmd <= 1'b1;
        acc(1'b0, 16'h8000, 1'b0, 1'b1, 16'h0000);
        chk_b("fw no reset", 1'b0, ill);
        cpu_fw_cmd <= 1'b0;
        acc(1'b1, 16'h8000, 1'b0, 1'b1, 16'h0000);
        chk_b("dbg no reset", 1'b0, ill);
        chk("dbg prog page", 18'h08000, t.addr);
        single_chip <= 1'b0;
        dbg_active <= 1'b1;
        for (i = 0; i < 5; i++)
        begin
            p = dbg_tbl[i][19:16];
            a = dbg_tbl[i][15:0];
            set_page(p);
            rd_cyc <= (dbg_tbl[i][21:20] == 2'd1);
            wr_cyc <= (dbg_tbl[i][21:20] == 2'd2);
            acc(1'b0, a, dbg_tbl[i][21], 1'b1, 16'h1234);
            hit = a >= 16'hFF00 || (p == 4'hF && a >= 16'hBF00
                  && a <= 16'hBFFF);
            exp_b = (dbg_tbl[i][21:20] != 2'd0) && hit;
            chk_b("dbg overlay", exp_b, t.dbg_sel);
            chk_b("hidden", ~hit, t.sel);
        end
        {dbg_active, rd_cyc, wr_cyc} <= 3'b000;
        set_page(4'h4);
        dbgpp_wr <= 1'b1;
        dbgpp_wdata <= 4'h6;
        dbg_page_en <= 1'b1;
        dbg_hw_cmd <= 1'b1;
        @(posedge ref_clk);
        dbgpp_wr <= 1'b0;
        // debug word access at even address only
        acc(1'b1, 16'h8010, 1'b0, 1'b1, 16'h0000);
        chk("dbg page hw", 18'h18010, t.addr);
        chk("dbg data", 18'(16'h8010 ^ 16'h5A3C), 18'(rd));
        dbg_hw_cmd <= 1'b0;
        acc(1'b1, 16'h8010, 1'b0, 1'b1, 16'h0000);
        chk("dbg page off", 18'h10010, t.addr);
        cpu_fw_cmd <= 1'b1;
        acc(1'b1, 16'h8010, 1'b0, 1'b1, 16'h0000);
        chk("dbg page fw", 18'h18010, t.addr);
        {cpu_fw_cmd, dbg_page_en} <= 2'b00;
        starve(0, n);
        chk_b("starve win", 1'b1, n >= 129 && n <= 132);
        do_reset();
        starve(200, n);
        chk_b("busy holds", 1'b1, n >= 201 && n <= 203);
        end_of_test();
    end
endmodule : memory_map_controller_tb
`default_nettype wire
